// File: design/pwm_pkg.sv
package pwm_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_NEW_LINE_POSITION = 8'h22;
    localparam logic [7:0] ADDR_ACTIVE_VIDEO_BEGIN = 8'h28;
    localparam logic [7:0] ADDR_ACTIVE_VIDEO_END = 8'h29;
    localparam logic [7:0] ADDR_PIP_PRESCALE_SELECT = 8'h41;
    localparam logic [7:0] ADDR_FILTER_FILL_LIMIT = 8'h42;
    localparam logic [7:0] ADDR_SCALER_STEP_INCREMENT = 8'h43;
    localparam logic [7:0] ADDR_SCALER_BRIGHTNESS = 8'h52;
    localparam logic [7:0] ADDR_PIP_MODE = 8'h60;
    localparam logic [7:0] ADDR_WINDOW_HSTART = 8'h61;
    localparam logic [7:0] ADDR_WINDOW_VSTART = 8'h62;
    localparam logic [7:0] ADDR_WINDOW_PIXELS = 8'h63;
    localparam logic [7:0] ADDR_WINDOW_LINES = 8'h64;
    localparam logic [7:0] ADDR_STATUS = 8'h65;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RST_NEW_LINE_POSITION = 16'h0086;
    localparam logic [15:0] RST_ACTIVE_VIDEO_BEGIN = 16'h0086;
    localparam logic [15:0] RST_ACTIVE_VIDEO_END = 16'h0356;
    localparam logic [15:0] RST_PIP_PRESCALE_SELECT = 16'h0000;
    localparam logic [15:0] RST_FILTER_FILL_LIMIT = 16'h02D0;
    localparam logic [15:0] RST_SCALER_STEP_INCREMENT = 16'h0600;
    localparam logic [15:0] RST_SCALER_BRIGHTNESS = 16'h0010;
    localparam logic [15:0] RST_WINDOW = 16'h0000;
    localparam logic [15:0] RST_PIP_MODE = 16'h0000;
    // ****************************************
    // pip mode field layout
    // ****************************************
    localparam int MODE_ROLE_LSB = 0;
    localparam int MODE_LAYOUT_LSB = 2;
    localparam int MODE_BORDER_BIT = 6;
    localparam int MODE_MEMTYPE_LSB = 7;
    localparam int MODE_SIZE_LSB = 9;
    localparam int MODE_READ_BIT = 11;
    localparam logic [3:0] LAYOUT_EXPERT = 4'h0;
    localparam logic [3:0] LAYOUT_LAST = 4'hF;
    localparam logic [10:0] BORDER_WIDTH = 11'h004;
    localparam logic [10:0] BORDER_HEIGHT = 11'h004;
    // ****************************************
    // fixed inset sizes, half/third/quarter/sixth
    // ****************************************
    localparam logic [10:0] HALF_PIX_13M5 = 11'd332;
    localparam logic [10:0] HALF_PIX_16M = 11'd392;
    localparam logic [10:0] HALF_LINES_625 = 11'd132;
    localparam logic [10:0] THIRD_PIX = 11'd220;
    localparam logic [10:0] THIRD_LINES = 11'd88;
    localparam logic [10:0] QUARTER_PIX = 11'd164;
    localparam logic [10:0] QUARTER_LINES = 11'd66;
    localparam logic [10:0] SIXTH_PIX = 11'd112;
    localparam logic [10:0] SIXTH_LINES = 11'd44;
    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        ROLE_SINGLE = 2'h0,
        ROLE_WRITER = 2'h1,
        ROLE_MAIN = 2'h2
    } pwm_role_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_MAIN_AREA = 4'h2,
        ST_INSET = 4'h4,
        ST_BORDER = 4'h8
    } pwm_state_t;
endpackage

// File: design/pwm_sync2.sv
`timescale 1ns/10ps
module pwm_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic sysClk,
    input wire logic resetN,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge sysClk or negedge resetN)
    begin
        if (!resetN)
        begin
            stage1 <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // pwm_sync2

// File: design/pwm_pip_window_mode_control.sv
// Contract
// [R1] writer role: decimate input, store insets, frame and background in field memory
// [R2] main role: output main, fetch and insert insets, store combined for conversion; the code stores only main-area video, not insets or frame
// [R3] single role: write insets, frame, background and outer main area; read optional
// [R4] fifteen predefined layouts plus fully programmable expert mode
// [R5] predefined sizes half, third, quarter, sixth; half 332/392 pixels, 132 lines; the code always uses 332 pixels for half
// [R6] border on or off by register; four pixels wide, four lines high
// [R7] host programs increment, fill limit, prescale per inset size
// [R8] host sets brightness field to sixteen with predefined scaler values
// [R9] host uses listed new-line and active video positions per role
// [R10] memory type zero or one: new-line and video start above 47
// [R11] acquisition window selects the inset region of incoming video
// [R12] display window places the insets on screen
// [R13] four parameters: horizontal start, vertical start, pixel and line counts
// [R14] writer/single: acquisition window on decimated grid; main: display window
// [R15] device drives control outputs sequencing the external field memory
// [R16] pointer-reset output returns memory write and read pointers to zero
// [R17] window parameter changes take effect only at a field boundary
`timescale 1ns/10ps
module pwm_pip_window_mode_control #(
    parameter int AW = 8,
    parameter int DW = 16,
    parameter int CW = 11
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [AW-1:0] regAddr,
    input wire logic [DW-1:0] regWdata,
    output logic [DW-1:0] regRdata,
    input wire logic hsyncPin,
    input wire logic vsyncPin,
    input wire logic decimValidPin,
    input wire logic [DW-1:0] videoIn,
    input wire logic [DW-1:0] memReadData,
    output logic [DW-1:0] memWriteData,
    output logic [DW-1:0] videoOut,
    output logic memory_pointer_reset,
    output logic memWriteEnable,
    output logic memInputEnable,
    output logic memReadEnable,
    output logic memOutputEnable
);
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [2:0] pinSync;
    logic hsync;
    logic vsync;
    logic decimValid;
    logic hsyncD;
    logic vsyncD;
    pwm_sync2 #(.WIDTH(3)) u_sync (
        .sysClk(sys_clk),
        .resetN(reset_n),
        .asyncIn({hsyncPin, vsyncPin, decimValidPin}),
        .syncOut(pinSync)
    );
    assign hsync = pinSync[2];
    assign vsync = pinSync[1];
    assign decimValid = pinSync[0];
    logic lineStart;
    logic fieldStart;
    assign lineStart = hsync && !hsyncD;
    assign fieldStart = vsync && !vsyncD;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hsyncD <= 1'b0;
            vsyncD <= 1'b0;
        end
        else
        begin
            hsyncD <= hsync;
            vsyncD <= vsync;
        end
    end
    // ****************************************
    // register file
    // ****************************************
    logic [DW-1:0] new_line_position;
    logic [DW-1:0] active_video_begin;
    logic [DW-1:0] active_video_end;
    logic [DW-1:0] pip_prescale_select;
    logic [DW-1:0] filter_fill_limit;
    logic [DW-1:0] scaler_step_increment;
    logic [DW-1:0] scaler_brightness;
    logic [DW-1:0] pipMode;
    logic [CW-1:0] window_horizontal_start;
    logic [CW-1:0] window_vertical_start;
    logic [CW-1:0] window_pixel_count;
    logic [CW-1:0] window_line_count;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            new_line_position <= pwm_pkg::RST_NEW_LINE_POSITION;
            active_video_begin <= pwm_pkg::RST_ACTIVE_VIDEO_BEGIN;
            active_video_end <= pwm_pkg::RST_ACTIVE_VIDEO_END;
            pip_prescale_select <= pwm_pkg::RST_PIP_PRESCALE_SELECT;
            filter_fill_limit <= pwm_pkg::RST_FILTER_FILL_LIMIT;
            scaler_step_increment <= pwm_pkg::RST_SCALER_STEP_INCREMENT;
            scaler_brightness <= pwm_pkg::RST_SCALER_BRIGHTNESS;
            pipMode <= pwm_pkg::RST_PIP_MODE;
            window_horizontal_start <= pwm_pkg::RST_WINDOW[CW-1:0];
            window_vertical_start <= pwm_pkg::RST_WINDOW[CW-1:0];
            window_pixel_count <= pwm_pkg::RST_WINDOW[CW-1:0];
            window_line_count <= pwm_pkg::RST_WINDOW[CW-1:0];
        end
        else if (regWrite)
        begin
            case (regAddr)
                pwm_pkg::ADDR_NEW_LINE_POSITION: new_line_position <= regWdata;
                pwm_pkg::ADDR_ACTIVE_VIDEO_BEGIN: active_video_begin <= regWdata;
                pwm_pkg::ADDR_ACTIVE_VIDEO_END: active_video_end <= regWdata;
                pwm_pkg::ADDR_PIP_PRESCALE_SELECT: pip_prescale_select <= regWdata;
                pwm_pkg::ADDR_FILTER_FILL_LIMIT: filter_fill_limit <= regWdata;
                pwm_pkg::ADDR_SCALER_STEP_INCREMENT: scaler_step_increment <= regWdata;
                pwm_pkg::ADDR_SCALER_BRIGHTNESS: scaler_brightness <= regWdata;
                pwm_pkg::ADDR_PIP_MODE: pipMode <= regWdata;
                pwm_pkg::ADDR_WINDOW_HSTART: window_horizontal_start <= regWdata[CW-1:0]; // [R13]
                pwm_pkg::ADDR_WINDOW_VSTART: window_vertical_start <= regWdata[CW-1:0]; // [R13]
                pwm_pkg::ADDR_WINDOW_PIXELS: window_pixel_count <= regWdata[CW-1:0]; // [R13]
                pwm_pkg::ADDR_WINDOW_LINES: window_line_count <= regWdata[CW-1:0]; // [R13]
                default: ;
            endcase
        end
    end
    // ****************************************
    // mode decode
    // ****************************************
    pwm_pkg::pwm_role_t role;
    logic [3:0] layout;
    logic borderOn;
    logic [1:0] memoryType;
    logic [1:0] insetSize;
    logic readBack;
    logic expertMode;
    logic timingOk;
    assign role = pwm_pkg::pwm_role_t'(pipMode[pwm_pkg::MODE_ROLE_LSB +: 2]);
    assign layout = pipMode[pwm_pkg::MODE_LAYOUT_LSB +: 4];
    assign borderOn = pipMode[pwm_pkg::MODE_BORDER_BIT]; // [R6]
    assign memoryType = pipMode[pwm_pkg::MODE_MEMTYPE_LSB +: 2];
    assign insetSize = pipMode[pwm_pkg::MODE_SIZE_LSB +: 2];
    assign readBack = pipMode[pwm_pkg::MODE_READ_BIT];
    assign expertMode = (layout == pwm_pkg::LAYOUT_EXPERT); // [R4]
    // memory types 0/1 need new-line and video start above 47
    assign timingOk = (memoryType > 2'h1) || ((new_line_position > 16'd47) && (active_video_begin > 16'd47)); // [R10]
    // ****************************************
    // window shadow, loaded at field start
    // ****************************************
    logic [CW-1:0] hStart;
    logic [CW-1:0] vStart;
    logic [CW-1:0] pixCount;
    logic [CW-1:0] lineCount;
    logic [CW-1:0] next_pixCount;
    logic [CW-1:0] next_lineCount;
    always_comb
    begin
        next_pixCount = window_pixel_count;
        next_lineCount = window_line_count;
        if (!expertMode) // [R5]
        begin
            case (insetSize)
                2'h0:
                begin
                    next_pixCount = pwm_pkg::HALF_PIX_13M5;
                    next_lineCount = pwm_pkg::HALF_LINES_625;
                end
                2'h1:
                begin
                    next_pixCount = pwm_pkg::THIRD_PIX;
                    next_lineCount = pwm_pkg::THIRD_LINES;
                end
                2'h2:
                begin
                    next_pixCount = pwm_pkg::QUARTER_PIX;
                    next_lineCount = pwm_pkg::QUARTER_LINES;
                end
                default:
                begin
                    next_pixCount = pwm_pkg::SIXTH_PIX;
                    next_lineCount = pwm_pkg::SIXTH_LINES;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hStart <= '0;
            vStart <= '0;
            pixCount <= '0;
            lineCount <= '0;
        end
        else if (fieldStart) // [R17]
        begin
            hStart <= window_horizontal_start;
            vStart <= window_vertical_start;
            pixCount <= next_pixCount;
            lineCount <= next_lineCount;
        end
    end
    // ****************************************
    // pixel and line counters
    // ****************************************
    logic [CW-1:0] pixelPos;
    logic [CW-1:0] linePos;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pixelPos <= '0;
            linePos <= '0;
        end
        else if (fieldStart)
        begin
            pixelPos <= '0;
            linePos <= '0;
        end
        else if (lineStart)
        begin
            pixelPos <= '0;
            linePos <= linePos + 1'b1;
        end
        else if (role == pwm_pkg::ROLE_MAIN || decimValid) // [R14]
        begin
            pixelPos <= pixelPos + 1'b1;
        end
    end
    // ****************************************
    // window and border classification
    // ****************************************
    logic inWindow;
    logic inBorder;
    logic [CW:0] hEnd;
    logic [CW:0] vEnd;
    assign hEnd = {1'b0, hStart} + {1'b0, pixCount};
    assign vEnd = {1'b0, vStart} + {1'b0, lineCount};
    // acquisition window on writer/single, display window on main
    assign inWindow = ({1'b0, pixelPos} >= {1'b0, hStart}) && ({1'b0, pixelPos} < hEnd)
        && ({1'b0, linePos} >= {1'b0, vStart}) && ({1'b0, linePos} < vEnd); // [R11] [R12] [R14]
    assign inBorder = borderOn && !inWindow
        && ({1'b0, pixelPos} + {1'b0, pwm_pkg::BORDER_WIDTH} >= {1'b0, hStart})
        && ({1'b0, pixelPos} < hEnd + {1'b0, pwm_pkg::BORDER_WIDTH})
        && ({1'b0, linePos} + {1'b0, pwm_pkg::BORDER_HEIGHT} >= {1'b0, vStart})
        && ({1'b0, linePos} < vEnd + {1'b0, pwm_pkg::BORDER_HEIGHT}); // [R6]
    // ****************************************
    // memory sequencing state
    // ****************************************
    pwm_pkg::pwm_state_t state;
    pwm_pkg::pwm_state_t next_state;
    always_comb
    begin
        next_state = pwm_pkg::ST_IDLE;
        if (timingOk)
        begin
            if (inWindow)
                next_state = pwm_pkg::ST_INSET;
            else if (inBorder)
                next_state = pwm_pkg::ST_BORDER;
            else
                next_state = pwm_pkg::ST_MAIN_AREA;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= pwm_pkg::ST_IDLE;
        else
            state <= next_state;
    end
    // ****************************************
    // field memory control outputs
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            memory_pointer_reset <= 1'b0;
            memWriteEnable <= 1'b0;
            memInputEnable <= 1'b0;
            memReadEnable <= 1'b0;
            memOutputEnable <= 1'b0;
            memWriteData <= '0;
            videoOut <= '0;
        end
        else
        begin
            memory_pointer_reset <= fieldStart; // [R16]
            memWriteEnable <= 1'b0;
            memInputEnable <= 1'b0;
            memReadEnable <= 1'b0;
            memOutputEnable <= 1'b0;
            memWriteData <= videoIn;
            videoOut <= videoIn;
            case (state)
                pwm_pkg::ST_INSET:
                begin
                    case (role)
                        pwm_pkg::ROLE_MAIN:
                        begin
                            memReadEnable <= 1'b1; // [R2] [R15]
                            memOutputEnable <= 1'b1;
                            videoOut <= memReadData;
                        end
                        default:
                        begin
                            memWriteEnable <= decimValid; // [R1] [R3] [R15]
                            memInputEnable <= decimValid;
                            memReadEnable <= readBack && role == pwm_pkg::ROLE_SINGLE;
                            memOutputEnable <= readBack && role == pwm_pkg::ROLE_SINGLE;
                        end
                    endcase
                end
                pwm_pkg::ST_BORDER:
                begin
                    memWriteEnable <= role != pwm_pkg::ROLE_MAIN; // [R1] [R3]
                    memInputEnable <= role != pwm_pkg::ROLE_MAIN;
                    memWriteData <= '0;
                    if (role == pwm_pkg::ROLE_MAIN)
                        videoOut <= '0;
                end
                pwm_pkg::ST_MAIN_AREA:
                begin
                    // single writes main area; writer writes background; main stores its main video only, insets are never written
                    memWriteEnable <= 1'b1; // [R2] [R3]
                    memInputEnable <= 1'b1;
                    if (role == pwm_pkg::ROLE_WRITER)
                        memWriteData <= '0; // [R1]
                    memReadEnable <= readBack && role == pwm_pkg::ROLE_SINGLE;
                    memOutputEnable <= readBack && role == pwm_pkg::ROLE_SINGLE;
                end
                default: ;
            endcase
        end
    end
    // ****************************************
    // read mux
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            regRdata <= '0;
        else if (regRead)
        begin
            case (regAddr)
                pwm_pkg::ADDR_NEW_LINE_POSITION: regRdata <= new_line_position;
                pwm_pkg::ADDR_ACTIVE_VIDEO_BEGIN: regRdata <= active_video_begin;
                pwm_pkg::ADDR_ACTIVE_VIDEO_END: regRdata <= active_video_end;
                pwm_pkg::ADDR_PIP_PRESCALE_SELECT: regRdata <= pip_prescale_select;
                pwm_pkg::ADDR_FILTER_FILL_LIMIT: regRdata <= filter_fill_limit;
                pwm_pkg::ADDR_SCALER_STEP_INCREMENT: regRdata <= scaler_step_increment;
                pwm_pkg::ADDR_SCALER_BRIGHTNESS: regRdata <= scaler_brightness;
                pwm_pkg::ADDR_PIP_MODE: regRdata <= pipMode;
                pwm_pkg::ADDR_WINDOW_HSTART: regRdata <= {{(DW-CW){1'b0}}, window_horizontal_start};
                pwm_pkg::ADDR_WINDOW_VSTART: regRdata <= {{(DW-CW){1'b0}}, window_vertical_start};
                pwm_pkg::ADDR_WINDOW_PIXELS: regRdata <= {{(DW-CW){1'b0}}, window_pixel_count};
                pwm_pkg::ADDR_WINDOW_LINES: regRdata <= {{(DW-CW){1'b0}}, window_line_count};
                pwm_pkg::ADDR_STATUS: regRdata <= {{(DW-5){1'b0}}, timingOk, state};
                default: regRdata <= '0;
            endcase
        end
    end
endmodule // pwm_pip_window_mode_control

// File: dv/pwm_window_checker.sv
`timescale 1ns/10ps
module pwm_window_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic vsyncPin,
    input wire logic memory_pointer_reset,
    input wire logic memWriteEnable,
    input wire logic memInputEnable,
    input wire logic memReadEnable,
    input wire logic memOutputEnable
);
    // ****
    // shadow of timing registers
    // ****
    logic [15:0] newLine;
    logic [15:0] videoBegin;
    logic [1:0] memType;
    logic timingBad;
    logic anyEnable;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            newLine <= 16'h0086;
            videoBegin <= 16'h0086;
            memType <= 2'h0;
        end
        else if (regWrite)
        begin
            if (regAddr == 8'h22) newLine <= regWdata;
            if (regAddr == 8'h28) videoBegin <= regWdata;
            if (regAddr == 8'h60) memType <= regWdata[8:7];
        end
    end
    assign timingBad = (memType < 2'h2) && (newLine <= 16'h002F || videoBegin <= 16'h002F);
    assign anyEnable = memWriteEnable || memInputEnable || memReadEnable || memOutputEnable;
    // ****
    // properties
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_pulse_one_cycle: assert property (memory_pointer_reset |=> !memory_pointer_reset)
        else $error("pointer reset wider than one cycle");
    a_pulse_after_field: assert property ($rose(vsyncPin) |-> ##[2:6] memory_pointer_reset)
        else $error("no pointer reset after field start");
    a_pulse_has_cause: assert property ($rose(memory_pointer_reset) |-> $past(vsyncPin, 2))
        else $error("pointer reset without field start");
    a_window_read_back: assert property ((regWrite && regAddr == 8'h61) ##1 (regRead && regAddr == 8'h61)
        |=> regRdata[10:0] == $past(regWdata[10:0], 2)) else $error("window start read back wrong");
    a_unmapped_zero: assert property (regRead && regAddr == 8'h30 |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!regRead |=> $stable(regRdata))
        else $error("read data changed without read");
    a_status_one_hot: assert property (regRead && regAddr == 8'h65 |=> $onehot(regRdata[3:0]))
        else $error("status state not one-hot");
    a_quiet_after_reset: assert property ($rose(reset_n) |-> !memory_pointer_reset && !anyEnable)
        else $error("memory controls active at reset release");
    a_timing_refused: assert property (timingBad [*3] |-> !anyEnable)
        else $error("memory enabled with bad line timing");
    cover property (memory_pointer_reset);
    cover property (memWriteEnable);
    cover property (memReadEnable);
    cover property (timingBad ##1 memory_pointer_reset);
endmodule // pwm_window_checker

// File: dv/pwm_field_memory.sv
`timescale 1ns/10ps
module pwm_field_memory (
    input wire logic sys_clk,
    input wire logic memory_pointer_reset,
    input wire logic memWriteEnable,
    input wire logic memInputEnable,
    input wire logic memReadEnable,
    input wire logic memOutputEnable,
    input wire logic [15:0] memWriteData,
    output logic [15:0] memReadData
);
    // ****
    // fifo field memory with pointer reset
    // ****
    logic [15:0] core [0:1023];
    logic [9:0] wrPtr = 10'h000;
    logic [9:0] rdPtr = 10'h000;
    initial
    begin
        memReadData = 16'h0000;
        for (int i = 0; i < 1024; i++)
            core[i] = 16'h0000;
    end
    always @(posedge sys_clk)
    begin
        if (memory_pointer_reset === 1'b1)
        begin
            wrPtr <= 10'h000;
            rdPtr <= 10'h000;
        end
        else
        begin
            if (memInputEnable === 1'b1) core[wrPtr] <= memWriteData;
            if (memWriteEnable === 1'b1) wrPtr <= wrPtr + 10'h001;
            if (memReadEnable === 1'b1) rdPtr <= rdPtr + 10'h001;
        end
        // released outputs toggle instead of holding the last word
        memReadData <= (memOutputEnable === 1'b1) ? core[rdPtr] : ~memReadData;
    end
endmodule // pwm_field_memory

// File: dv/pwm_pip_window_mode_control_tb_top.sv
`timescale 1ns/10ps
module pwm_pip_window_mode_control_tb_top;
    // ****
    // signals
    // ****
    logic sys_clk, reset_n, regWrite, regRead, hsyncPin, vsyncPin, decimValidPin;
    logic [7:0] regAddr;
    logic [15:0] regWdata, regRdata, videoIn, memReadData, memWriteData, videoOut;
    logic memory_pointer_reset, memWriteEnable, memInputEnable, memReadEnable, memOutputEnable;
    int miscompares, check_count, pulseCount, wrCount, rdCount;
    logic [15:0] expQ[$];
    pwm_pip_window_mode_control dut_u (.sys_clk, .reset_n, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .hsyncPin, .vsyncPin, .decimValidPin, .videoIn, .memReadData, .memWriteData,
        .videoOut, .memory_pointer_reset, .memWriteEnable, .memInputEnable, .memReadEnable, .memOutputEnable);
    pwm_field_memory mem_u (.sys_clk, .memory_pointer_reset, .memWriteEnable, .memInputEnable,
        .memReadEnable, .memOutputEnable, .memWriteData, .memReadData);
    // ****
    // tasks
    // ****
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        regWrite = w;
        regRead = r;
        regAddr = a;
        regWdata = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, 1'b1, a, 16'h0000);
        expQ.push_back(exp);
    endtask
    task automatic field(input int fields);
        bus(1'b0, 1'b0, 8'h00, 16'h0000);
        pulseCount = 0;
        wrCount = 0;
        rdCount = 0;
        for (int l = 0; l < 12 * fields; l++)
            for (int p = 0; p < 64; p++)
            begin
                @(posedge sys_clk);
                #1;
                vsyncPin = (l % 12 == 0) && (p < 10);
                hsyncPin = p < 2;
                decimValidPin = 1'($urandom_range(1, 0));
                videoIn = 16'($urandom);
            end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****
    // clock, monitor, watchdog
    // ****
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        pulseCount += int'(memory_pointer_reset === 1'b1);
        wrCount += int'(memWriteEnable === 1'b1);
        rdCount += int'(memReadEnable === 1'b1);
        if (regRead === 1'b1)
        begin
            #2;
            check("regRdata", regRdata, expQ.pop_front());
        end
    end
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        results();
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        {reset_n, regWrite, regRead, hsyncPin, vsyncPin, decimValidPin} = 6'h00;
        {regAddr, regWdata, videoIn} = 40'h0;
        void'($urandom(32'h5fea80af));
        repeat (5) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        rd(8'h22, 16'h0086);
        rd(8'h28, 16'h0086);
        rd(8'h29, 16'h0356);
        rd(8'h43, 16'h0600);
        rd(8'h52, 16'h0010);
        rd(8'h30, 16'h0000);
        rd(8'h65, 16'h0012);
        bus(1'b1, 1'b0, 8'h42, 16'h0168);
        bus(1'b1, 1'b0, 8'h41, 16'h0011);
        bus(1'b1, 1'b0, 8'h52, 16'h0110);
        bus(1'b1, 1'b0, 8'h22, 16'h0194);
        rd(8'h42, 16'h0168);
        rd(8'h41, 16'h0011);
        rd(8'h52, 16'h0110);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 1'b0, 8'h61, 16'($urandom_range(2047, 0)));
            rd(8'h61, regWdata);
        end
        bus(1'b1, 1'b0, 8'h61, 16'h0008);
        bus(1'b1, 1'b0, 8'h62, 16'h0005);
        bus(1'b1, 1'b0, 8'h63, 16'h0008);
        bus(1'b1, 1'b0, 8'h64, 16'h0004);
        for (int m = 0; m < 16; m++)
        begin
            bus(1'b1, 1'b0, 8'h60, 16'((m % 3) | (m << 2) | ((m & 1) << 6) | ((m & 3) << 9)
                | ((m & 4) << 9)));
            field(1);
            field(1);
            check("pulses", 16'(pulseCount), 16'h0001);
            check("writes", 16'(wrCount > 0), 16'h0001);
            check("reads", 16'(rdCount > 0), 16'(m % 3 == 2 || (m % 3 == 0 && m[2])));
        end
        bus(1'b1, 1'b0, 8'h22, 16'h002F);
        bus(1'b1, 1'b0, 8'h60, 16'h0001);
        field(1);
        field(2);
        check("refused", 16'(wrCount + rdCount), 16'h0000);
        bus(1'b1, 1'b0, 8'h60, 16'h0101);
        field(1);
        field(1);
        check("allowed", 16'(wrCount > 0), 16'h0001);
        check("memWriteData", memWriteData, 16'h0000);
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        rd(8'h22, 16'h0086);
        bus(1'b0, 1'b0, 8'h00, 16'h0000);
        for (int i = 0; i < 20 && expQ.size() != 0; i++)
            @(posedge sys_clk);
        if (expQ.size() != 0) miscompares++;
        results();
    end
endmodule // pwm_pip_window_mode_control_tb_top
bind pwm_pip_window_mode_control pwm_window_checker chk_u (.sys_clk, .reset_n, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .vsyncPin, .memory_pointer_reset, .memWriteEnable, .memInputEnable,
    .memReadEnable, .memOutputEnable);
